// ---- include/fllcg_pkg.sv ----
/*
 Register map, field layouts, reset values and loop constants of the FLL clock generator.
 Assumes a 50 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package fllcg_pkg;
    // ------------------------------------------------------------
    // Register map and bus
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL1_A = 8'h00;
    localparam logic [7:0] REG_CTRL2_A = 8'h04;
    localparam logic [7:0] REG_TRIM_A = 8'h08;
    localparam logic [7:0] REG_CSC_A = 8'h0c;
    localparam logic [2:0] AHB_SIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        SRC_FLL = 2'b00,
        SRC_INT = 2'b01,
        SRC_EXT = 2'b10,
        SRC_RSVD = 2'b11
    } fllcg_src_t;

    typedef struct packed {
        fllcg_src_t clk_src;
        logic [2:0] reference_divide_select;
        logic int_ref_select;
        logic int_ref_clock_enable;
        logic int_ref_stop_enable;
    } fllcg_ctrl1_t;

    typedef struct packed {
        logic [1:0] bus_divider_select;
        logic osc_range;
        logic high_gain_oscillator_select;
        logic low_power;
        logic external_ref_type_select;
        logic external_ref_clock_enable;
        logic external_ref_stop_enable;
    } fllcg_ctrl2_t;

    typedef struct packed {
        logic [1:0] dco_range_select;
        logic max_freq_32k_select;
        logic int_ref_status;
        fllcg_src_t clock_status;
        logic [1:0] dco_range_status;
    } fllcg_csc_t;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam fllcg_ctrl1_t CTRL1_RST = 8'h04;
    localparam fllcg_ctrl2_t CTRL2_RST = 8'h40;
    localparam logic [1:0] BUS_DIVIDER_SELECT_RST = 2'h1;
    localparam logic [1:0] DCO_LOW_RANGE = 2'h0;
    localparam int TRIM_W = 9;
    localparam logic [8:0] TRIM_RST = 9'h100;

    // ------------------------------------------------------------
    // Oscillators and loop
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 50000000;
    localparam longint IREF_HZ = 32768;
    localparam int NCO_W = 32;
    localparam logic [31:0] IREF_INC = 32'((IREF_HZ << NCO_W) / CLK_HZ);
    localparam logic [31:0] TRIM_STEP_DIV = 32'h0000_0200;
    localparam logic [31:0] TRIM_STEP = IREF_INC / TRIM_STEP_DIV;
    localparam logic [31:0] IREF_BASE = IREF_INC - TRIM_STEP * 32'(TRIM_RST);
    localparam int FLL_CNT_W = 11;
    localparam logic [10:0] FLL_MULT_STD = 11'h200;
    localparam logic [10:0] FLL_MULT_32K = 11'h260;
    localparam logic [31:0] FLL_TUNE_RST = IREF_INC * 32'(FLL_MULT_STD);
    localparam int FLL_GAIN_SH = 20;
    localparam int REF_CNT_W = 10;
    localparam logic [3:0] REF_DIV_RANGE_SH = 4'h5;
    localparam logic [3:0] REF_DIV_MAX_SH = 4'ha;
endpackage : fllcg_pkg

// ---- hdl/fllcg_nco.sv ----
/*
 Numerically controlled oscillator: phase accumulator whose top bit is the clock level.
 Assumes one free-running system clock; run_i low freezes the phase without clearing it.
*/
module fllcg_nco #(
    parameter int W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [W-1:0] inc_i,
    output logic lvl_o,
    output logic rise_o
);
    logic [W-1:0] acc_ff;
    logic rise_ff;
    wire logic [W-1:0] nxt_acc = run_i ? acc_ff + inc_i : acc_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_ff <= '0;
            rise_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            rise_ff <= !acc_ff[W-1] && nxt_acc[W-1];
        end
    end

    assign lvl_o = acc_ff[W-1];
    assign rise_o = rise_ff;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    phase_hold_a: assert property (!run_i |=> $stable(acc_ff))
        else $error("Oscillator phase moved while halted");
    rise_mark_a: assert property (rise_o |-> lvl_o && !$past(lvl_o))
        else $error("Rise pulse without a rising level");
endmodule : fllcg_nco

// ---- hdl/fllcg_busdiv.sv ----
/*
 Source switch and bus divider: picks one of three edge streams and divides it by 1, 2, 4 or 8.
 Assumes each ev_i bit pulses on both edges of its source; a new source or factor is taken
 only while the output rests low between counts.
*/
module fllcg_busdiv #(
    parameter int CNT_W = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [2:0] ev_i,
    input wire logic [1:0] sel_i,
    input wire logic [1:0] div_i,
    output logic clk_o,
    output logic [1:0] act_sel_o
);
    logic clk_ff;
    logic [1:0] act_sel_ff;
    logic [1:0] act_div_ff;
    logic [CNT_W-1:0] cnt_ff;
    wire logic [CNT_W-1:0] lim = CNT_W'((32'd1 << act_div_ff) - 32'd1);
    wire logic ev = run_i && act_sel_ff != fllcg_pkg::SRC_RSVD && ev_i[act_sel_ff];
    wire logic wrap = ev && cnt_ff == lim;
    wire logic idle_low = !clk_ff && cnt_ff == '0 && !ev;

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            clk_ff <= 1'b0;
            cnt_ff <= '0;
        end else if (ev) begin
            clk_ff <= wrap ? !clk_ff : clk_ff;
            cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_sel_ff <= fllcg_pkg::SRC_FLL;
            act_div_ff <= fllcg_pkg::BUS_DIVIDER_SELECT_RST;
        end else if (idle_low) begin
            act_sel_ff <= sel_i;
            act_div_ff <= div_i;
        end
    end

    assign clk_o = clk_ff;
    assign act_sel_o = act_sel_ff;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    div_toggle_a: assert property ($changed(clk_ff) && $past(run_i) && !$past(rst_i) |-> $past(wrap))
        else $error("Bus clock toggled off its count");
    safe_switch_a: assert property ($changed(act_sel_ff) || $changed(act_div_ff) |-> !clk_ff)
        else $error("Source or factor changed while clock high");
endmodule : fllcg_busdiv

// ---- hdl/fllcg_top.sv ----
/*
 FLL clock source generator: AHB-Lite registers, internal reference oscillator with trim,
 external reference divider, frequency-locked loop, source switch, bus divider, debug clock
 and crystal oscillator controls.
 Assumes EXT_REF_CLK_I and STOP_I are synchronous to CLK_I; the external reference is slow
 next to CLK_I; clocks are produced as levels sampled on CLK_I.
*/
// Our own choices: register access over AHB-Lite and the register addresses.
module fllcg_top (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic STOP_I,
    input wire logic EXT_REF_CLK_I,
    output logic BUS_CLK_O,
    output logic DEBUG_CLK_O,
    output logic INT_REF_CLK_O,
    output logic OSC_HIGH_GAIN_O,
    output logic OSC_RANGE_O,
    output logic OSC_REF_TYPE_O,
    output logic OSC_CLK_EN_O,
    output logic OSC_STOP_EN_O
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic wr_ff;
    logic [7:0] wa_ff;
    logic [31:0] rdata_ff;
    logic ready_ff;
    logic resp_ff;
    fllcg_pkg::fllcg_ctrl1_t c1_ff;
    fllcg_pkg::fllcg_ctrl2_t c2_ff;
    logic [fllcg_pkg::TRIM_W-1:0] trim_ff;
    logic [1:0] drs_ff;
    logic max32_ff;
    logic [1:0] dco_range_status_ff;
    logic irefst_ff;
    logic [1:0] act_src;

    wire logic ahb_go = HSEL_I && HTRANS_I[1] && HREADY_I;
    wire logic [7:0] ra = HADDR_I[7:0];
    wire fllcg_pkg::fllcg_csc_t csc = '{
        dco_range_select: drs_ff,
        max_freq_32k_select: max32_ff,
        int_ref_status: irefst_ff,
        clock_status: fllcg_pkg::fllcg_src_t'(act_src),
        dco_range_status: dco_range_status_ff
    };
    wire logic [31:0] rd_mux =
        (ra == fllcg_pkg::REG_CTRL1_A) ? 32'(c1_ff) :
        (ra == fllcg_pkg::REG_CTRL2_A) ? 32'(c2_ff) :
        (ra == fllcg_pkg::REG_TRIM_A) ? 32'(trim_ff) :
        (ra == fllcg_pkg::REG_CSC_A) ? 32'(csc) : '0;
    wire logic wr_c1 = wr_ff && wa_ff == fllcg_pkg::REG_CTRL1_A;
    wire logic wr_c2 = wr_ff && wa_ff == fllcg_pkg::REG_CTRL2_A;
    wire logic wr_trim = wr_ff && wa_ff == fllcg_pkg::REG_TRIM_A;
    wire logic wr_csc = wr_ff && wa_ff == fllcg_pkg::REG_CSC_A;
    wire fllcg_pkg::fllcg_csc_t wr_csc_val = fllcg_pkg::fllcg_csc_t'(HWDATA_I[7:0]);

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            wr_ff <= 1'b0;
            wa_ff <= '0;
            rdata_ff <= '0;
            ready_ff <= 1'b1;
            resp_ff <= 1'b0;
        end else begin
            wr_ff <= ahb_go && HWRITE_I && HSIZE_I == fllcg_pkg::AHB_SIZE_WORD;
            wa_ff <= ra;
            rdata_ff <= (ahb_go && !HWRITE_I) ? rd_mux : '0;
            ready_ff <= 1'b1;
            resp_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            c1_ff <= fllcg_pkg::CTRL1_RST;
            c2_ff <= fllcg_pkg::CTRL2_RST;
            trim_ff <= fllcg_pkg::TRIM_RST;
            drs_ff <= fllcg_pkg::DCO_LOW_RANGE;
            max32_ff <= 1'b0;
        end else begin
            if (wr_c1) c1_ff <= fllcg_pkg::fllcg_ctrl1_t'(HWDATA_I[7:0]);
            if (wr_c2) c2_ff <= fllcg_pkg::fllcg_ctrl2_t'(HWDATA_I[7:0]);
            if (wr_trim) trim_ff <= HWDATA_I[fllcg_pkg::TRIM_W-1:0];
            if (wr_csc) drs_ff <= wr_csc_val.dco_range_select;
            if (wr_csc) max32_ff <= wr_csc_val.max_freq_32k_select;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            dco_range_status_ff <= fllcg_pkg::DCO_LOW_RANGE;
            irefst_ff <= 1'b1;
        end else begin
            dco_range_status_ff <= drs_ff;
            irefst_ff <= c1_ff.int_ref_select;
        end
    end

    // ------------------------------------------------------------
    // Mode decode and oscillators
    // ------------------------------------------------------------
    logic iref_lvl;
    logic iref_rise;
    logic dco_lvl;
    logic dco_rise;
    logic [31:0] tune_ff;

    wire fllcg_pkg::fllcg_src_t src_sel =
        (c1_ff.clk_src == fllcg_pkg::SRC_RSVD) ? fllcg_pkg::SRC_FLL : c1_ff.clk_src;
    wire logic fll_bypass = src_sel != fllcg_pkg::SRC_FLL;
    wire logic fll_on = !STOP_I && !(fll_bypass && c2_ff.low_power);
    wire logic low_range = drs_ff == fllcg_pkg::DCO_LOW_RANGE && dco_range_status_ff == fllcg_pkg::DCO_LOW_RANGE;
    wire logic dco_run = fll_on && low_range;
    wire logic iref_run = !STOP_I || (c1_ff.int_ref_clock_enable && c1_ff.int_ref_stop_enable);
    wire logic [31:0] iref_inc = fllcg_pkg::IREF_BASE + 32'(trim_ff) * fllcg_pkg::TRIM_STEP;

    fllcg_nco #(
        .W(fllcg_pkg::NCO_W)
    ) u_iref (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .run_i(iref_run),
        .inc_i(iref_inc),
        .lvl_o(iref_lvl),
        .rise_o(iref_rise)
    );

    fllcg_nco #(
        .W(fllcg_pkg::NCO_W)
    ) u_dco (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .run_i(dco_run),
        .inc_i(tune_ff),
        .lvl_o(dco_lvl),
        .rise_o(dco_rise)
    );

    // ------------------------------------------------------------
    // External reference divider
    // ------------------------------------------------------------
    logic ext_ff;
    logic ext_prev_ff;
    logic [fllcg_pkg::REF_CNT_W-1:0] rcnt_ff;
    logic reference_divide_select_ev_ff;

    wire logic ext_rise = ext_ff && !ext_prev_ff;
    wire logic [3:0] reference_divide_select_raw = c2_ff.osc_range ?
        4'(c1_ff.reference_divide_select) + fllcg_pkg::REF_DIV_RANGE_SH :
        4'(c1_ff.reference_divide_select);
    wire logic [3:0] reference_divide_select_sh = (reference_divide_select_raw > fllcg_pkg::REF_DIV_MAX_SH) ? fllcg_pkg::REF_DIV_MAX_SH : reference_divide_select_raw;
    wire logic [fllcg_pkg::REF_CNT_W-1:0] reference_divide_select_lim = fllcg_pkg::REF_CNT_W'((32'd1 << reference_divide_select_sh) - 32'd1);

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ext_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            ext_ff <= EXT_REF_CLK_I;
            ext_prev_ff <= ext_ff;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || !fll_on) begin
            rcnt_ff <= '0;
            reference_divide_select_ev_ff <= 1'b0;
        end else begin
            reference_divide_select_ev_ff <= ext_rise && rcnt_ff == reference_divide_select_lim;
            if (ext_rise) rcnt_ff <= (rcnt_ff == reference_divide_select_lim) ? '0 : rcnt_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Frequency-locked loop
    // ------------------------------------------------------------
    logic [fllcg_pkg::FLL_CNT_W-1:0] fcnt_ff;
    logic fll_valid_ff;

    wire logic fll_ref_ev = c1_ff.int_ref_select ? iref_rise : reference_divide_select_ev_ff;
    wire logic [fllcg_pkg::FLL_CNT_W-1:0] fll_target =
        max32_ff ? fllcg_pkg::FLL_MULT_32K : fllcg_pkg::FLL_MULT_STD;
    wire logic signed [fllcg_pkg::FLL_CNT_W:0] fll_err =
        $signed({1'b0, fll_target}) - $signed({1'b0, fcnt_ff});
    wire logic [31:0] fll_step = 32'(fll_err) <<< fllcg_pkg::FLL_GAIN_SH;
    wire logic [31:0] nxt_tune = tune_ff + fll_step;
    wire logic fll_update = dco_run && fll_ref_ev && fll_valid_ff;

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || !dco_run) begin
            fcnt_ff <= '0;
            fll_valid_ff <= 1'b0;
        end else if (fll_ref_ev) begin
            fcnt_ff <= '0;
            fll_valid_ff <= 1'b1;
        end else if (dco_rise && fcnt_ff != '1) begin
            fcnt_ff <= fcnt_ff + 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            tune_ff <= fllcg_pkg::FLL_TUNE_RST;
        end else if (fll_update) begin
            tune_ff <= nxt_tune;
        end
    end

    // ------------------------------------------------------------
    // Clock outputs
    // ------------------------------------------------------------
    logic dco_prev_ff;
    logic iref_prev_ff;
    logic dbg_ff;
    logic iref_out_ff;
    logic bus_clk;

    wire logic [2:0] src_ev = {ext_ff ^ ext_prev_ff, iref_lvl ^ iref_prev_ff, dco_lvl ^ dco_prev_ff};

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            dco_prev_ff <= 1'b0;
            iref_prev_ff <= 1'b0;
            iref_out_ff <= 1'b0;
        end else begin
            dco_prev_ff <= dco_lvl;
            iref_prev_ff <= iref_lvl;
            iref_out_ff <= iref_lvl && iref_run && c1_ff.int_ref_clock_enable;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || !dco_run) begin
            dbg_ff <= 1'b0;
        end else if (dco_rise) begin
            dbg_ff <= !dbg_ff;
        end
    end

    fllcg_busdiv #(
        .CNT_W(3)
    ) u_busdiv (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .run_i(!STOP_I),
        .ev_i(src_ev),
        .sel_i(src_sel),
        .div_i(c2_ff.bus_divider_select),
        .clk_o(bus_clk),
        .act_sel_o(act_src)
    );

    assign HRDATA_O = rdata_ff;
    assign HREADYOUT_O = ready_ff;
    assign HRESP_O = resp_ff;
    assign BUS_CLK_O = bus_clk;
    assign DEBUG_CLK_O = dbg_ff;
    assign INT_REF_CLK_O = iref_out_ff;
    assign OSC_HIGH_GAIN_O = c2_ff.high_gain_oscillator_select;
    assign OSC_RANGE_O = c2_ff.osc_range;
    assign OSC_REF_TYPE_O = c2_ff.external_ref_type_select;
    assign OSC_CLK_EN_O = c2_ff.external_ref_clock_enable;
    assign OSC_STOP_EN_O = c2_ff.external_ref_stop_enable;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence ctrl2_addr_s;
        ahb_go && HWRITE_I && ra == fllcg_pkg::REG_CTRL2_A && HSIZE_I == fllcg_pkg::AHB_SIZE_WORD;
    endsequence

    sequence trim_addr_s;
        ahb_go && HWRITE_I && ra == fllcg_pkg::REG_TRIM_A && HSIZE_I == fllcg_pkg::AHB_SIZE_WORD;
    endsequence

    sequence csc_addr_s;
        ahb_go && HWRITE_I && ra == fllcg_pkg::REG_CSC_A && HSIZE_I == fllcg_pkg::AHB_SIZE_WORD;
    endsequence

    reset_mode_a: assert property ($past(SYS_RST_I) |->
        c1_ff.clk_src == fllcg_pkg::SRC_FLL && c1_ff.int_ref_select)
        else $error("Reset did not select loop engaged internal");
    bus_divider_select_reset_a: assert property ($past(SYS_RST_I) |-> c2_ff.bus_divider_select == fllcg_pkg::BUS_DIVIDER_SELECT_RST)
        else $error("Bus divider did not reset to divide by 2");
    ref_pick_a: assert property ($changed(tune_ff) |-> $past(c1_ff.int_ref_select ? iref_rise : reference_divide_select_ev_ff))
        else $error("Loop updated off the selected reference");
    fll_gain_a: assert property (fll_update && fcnt_ff < fll_target |=> tune_ff > $past(tune_ff))
        else $error("Loop did not speed up below target count");
    range_gate_a: assert property (drs_ff != fllcg_pkg::DCO_LOW_RANGE |=> $stable(dco_lvl) && !DEBUG_CLK_O)
        else $error("Clock produced outside low range");
    stop_hold_a: assert property (STOP_I |=> $stable(tune_ff) && !DEBUG_CLK_O && !BUS_CLK_O)
        else $error("Clocks or tuning moved in stop");
    debug_half_a: assert property (dco_run && dco_rise |=> DEBUG_CLK_O != $past(DEBUG_CLK_O))
        else $error("Debug clock missed a DCO rise");
    ref_div_a: assert property (reference_divide_select_ev_ff |-> $past(ext_rise && rcnt_ff == reference_divide_select_lim))
        else $error("Divided reference pulsed early");
    osc_ctrl_a: assert property (ctrl2_addr_s ##1 1'b1 |=> OSC_HIGH_GAIN_O == $past(HWDATA_I[4]))
        else $error("Oscillator gain line missed a write");
    osc_lines_a: assert property (ctrl2_addr_s ##1 1'b1 |=>
        OSC_RANGE_O == $past(HWDATA_I[5]) && OSC_CLK_EN_O == $past(HWDATA_I[1]))
        else $error("Oscillator range or enable missed a write");
    trim_write_a: assert property (trim_addr_s ##1 1'b1 |=>
        trim_ff == $past(HWDATA_I[fllcg_pkg::TRIM_W-1:0]))
        else $error("Trim value missed a write");
    max32_write_a: assert property (csc_addr_s ##1 1'b1 |=> max32_ff == $past(HWDATA_I[5]))
        else $error("Maximum frequency option missed a write");
    debug_from_loop_a: assert property ($rose(DEBUG_CLK_O) |-> $past(dco_rise))
        else $error("Debug clock rose without a loop rise");
    bus_from_src_a: assert property ($changed(BUS_CLK_O) && !$past(STOP_I) |-> $past(src_ev[act_src]))
        else $error("Bus clock moved off the active source");
    switch_low_a: assert property ($changed(act_src) |-> !BUS_CLK_O)
        else $error("Source switched while bus clock high");
endmodule : fllcg_top

// ---- tb/fllcg_crystal_oscillator_model.sv ----
/*
 Crystal oscillator model that drives the external reference clock level.
 Assumes the bench clock; the line runs only while enabled, and in stop only with stop enable.
*/
module fllcg_crystal_oscillator_model #(
    parameter int HALF = 20
) (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic stop_i,
    input wire logic stop_en_i,
    output logic ref_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    wire logic run = en_i && (!stop_i || stop_en_i);
    initial ref_o = 1'b0;
    always @(posedge clk_i) begin
        if (!run) begin
            cnt <= 0;
            ref_o <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            ref_o <= !ref_o;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : fllcg_crystal_oscillator_model

// ---- tb/fllcg_top_tb.sv ----
/*
 Self-checking bench for the FLL clock generator: AHB-Lite register tasks and clock counters.
 Assumes the design answers with no wait states and the oscillator model drives the reference.
*/
module fllcg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int HALF = 20;
    localparam int WIN = 3052;
    localparam int LIMIT = 95000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic stop = 1'b0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic ext_ref, bus_clk, dbg_clk, int_clk, o_gain, o_range, o_type, o_en, o_sten;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int cb, cd, ci;
    always #10 clk = !clk;
    fllcg_top u_dut (.CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .STOP_I(stop), .EXT_REF_CLK_I(ext_ref),
        .BUS_CLK_O(bus_clk), .DEBUG_CLK_O(dbg_clk), .INT_REF_CLK_O(int_clk), .OSC_HIGH_GAIN_O(o_gain),
        .OSC_RANGE_O(o_range), .OSC_REF_TYPE_O(o_type), .OSC_CLK_EN_O(o_en), .OSC_STOP_EN_O(o_sten));
    fllcg_crystal_oscillator_model #(.HALF(HALF)) u_crystal_oscillator (.clk_i(clk), .en_i(o_en), .stop_i(stop), .stop_en_i(o_sten),
        .ref_o(ext_ref));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            miscompares = miscompares + 1;
            conclude();
        end
    end
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_eq
    task automatic check_near(input int got, input int exp, input int tol);
        check_count++;
        if (got > exp + tol || got < exp - tol) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_near
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        hsize <= fllcg_pkg::AHB_SIZE_WORD;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        ahb(1'b1, addr, wd, rd);
    endtask : wr
    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, addr, 32'h0, rd);
        check_eq(rd, exp);
    endtask : rd_chk
    task automatic count(input int n, output int b, output int d);
        logic pb, pd, pi;
        pb = bus_clk;
        pd = dbg_clk;
        pi = int_clk;
        b = 0;
        d = 0;
        ci = 0;
        repeat (n) begin
            @(posedge clk);
            if (bus_clk === 1'b1 && pb === 1'b0) b++;
            if (dbg_clk === 1'b1 && pd === 1'b0) d++;
            if (int_clk === 1'b1 && pi === 1'b0) ci++;
            pb = bus_clk;
            pd = dbg_clk;
            pi = int_clk;
        end
    endtask : count
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(32'h00, 32'h04);
        rd_chk(32'h04, 32'h40);
        rd_chk(32'h08, 32'h100);
        rd_chk(32'h0c, 32'h10);
        rd_chk(32'h10, 32'h0);
        wr(32'h08, 32'hffff_ffff);
        rd_chk(32'h08, 32'h1ff);
        wr(32'h08, 32'h100);
        $display("test reset done");
        repeat (12 * 1526) @(posedge clk);
        count(WIN, cb, cd);
        check_near(cd, 512, 8);
        check_near(cb, 512, 8);
        $display("test default mode done");
        stop <= 1'b1;
        repeat (4) @(posedge clk);
        count(300, cb, cd);
        check_near(cb + cd, 0, 0);
        stop <= 1'b0;
        repeat (1526) @(posedge clk);
        count(WIN, cb, cd);
        check_near(cd, 512, 8);
        $display("test stop done");
        wr(32'h0c, 32'h20);
        rd_chk(32'h0c, 32'h30);
        repeat (12 * 1526) @(posedge clk);
        count(WIN, cb, cd);
        check_near(cd, 608, 8);
        wr(32'h0c, 32'h40);
        repeat (10) @(posedge clk);
        rd_chk(32'h0c, 32'h51);
        count(300, cb, cd);
        check_near(cd, 0, 0);
        wr(32'h0c, 32'h00);
        $display("test loop range done");
        wr(32'h04, 32'h75);
        repeat (2) @(posedge clk);
        check_eq({27'h0, o_gain, o_range, o_type, o_en, o_sten}, 32'h1d);
        $display("test oscillator pins done");
        wr(32'h00, 32'h84);
        for (int d = 0; d < 4; d++) begin
            wr(32'h04, 32'(d * 64 + 2));
            repeat (400) @(posedge clk);
            count(1280, cb, cd);
            check_near(cb, 32 >> d, 1);
        end
        rd_chk(32'h0c, 32'h18);
        wr(32'h04, 32'h02);
        wr(32'h00, 32'h46);
        repeat (200) @(posedge clk);
        count(WIN, cb, cd);
        check_near(cb, 2, 1);
        check_near(ci, 2, 1);
        $display("test sources and divider done");
        wr(32'h04, 32'h42);
        wr(32'h00, 32'h28);
        repeat (16 * 1280) @(posedge clk);
        count(2560, cb, cd);
        check_near(cd, 512, 8);
        check_near(cb, 512, 8);
        $display("test external loop done");
        conclude();
    end
endmodule : fllcg_top_tb
